// ==== shared/mss_regs.vh ====
// Register map, field positions and reset values of the masked step sequencer
`ifndef MSS_REGS_VH
`define MSS_REGS_VH
`define MSS_OFF_CTRL     12'h000
`define MSS_OFF_STATUS   12'h004
`define MSS_OFF_COUNT    12'h008
`define MSS_OFF_INDEX    12'h00C
`define MSS_OFF_MASK     12'h010
`define MSS_OFF_SOURCE   12'h014
`define MSS_OFF_DEST     12'h018
`define MSS_OFF_FAULT    12'h01C
`define MSS_OFF_TABLE    12'h100
`define MSS_CTRL_CMP_EN  0
`define MSS_CTRL_OUT_EN  1
`define MSS_CTRL_LOAD_EN 2
`define MSS_CTRL_RUN     3
`define MSS_CTRL_PRESCAN 4
`define MSS_CTRL_CLEAR   5
`define MSS_CTRL_MSK_W   9:8
`define MSS_CTRL_SRC_W   11:10
`define MSS_ST_FAULT     0
`define MSS_ST_CMP_OUT   1
`define MSS_ST_OUT_ACT   2
`define MSS_ST_OUT_CMP   3
`define MSS_ST_OUT_OUT   4
`define MSS_ST_LD_ACT    5
`define MSS_ST_LD_CMP    6
`define MSS_ST_LD_OUT    7
`define MSS_ST_MAJOR     8
`define MSS_W_8          2'h0
`define MSS_W_16         2'h1
`define MSS_FAULT_TYPE   8'h04
`define MSS_FAULT_CODE   8'h14
`define MSS_RST_WORD     32'h00000000
`endif

// ==== design/mss_table_mem.v ====
// Sequencer table storage with registered read data
`timescale 1ns/1ps
`default_nettype none
module mss_table_mem #(
  parameter AW = 4,
  parameter DW = 32
) (
  // Clock
  input  wire          clk,
  // Write port
  input  wire          we,
  input  wire [AW-1:0] waddr,
  input  wire [DW-1:0] wdata,
  // Read ports
  input  wire [AW-1:0] raddr_a,
  output reg  [DW-1:0] rdata_a,
  input  wire [AW-1:0] raddr_b,
  output reg  [DW-1:0] rdata_b
);
  reg [DW-1:0] mem [0:(1<<AW)-1];

  always @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata_a <= mem[raddr_a];
    rdata_b <= mem[raddr_b];
  end
endmodule // mss_table_mem
`default_nettype wire

// ==== design/mss_top.v ====
// Masked step sequencer with AHB-Lite register slave
//
// Summary of operation
// - Zero mask bits excluded from compare.
// - Masked equality drives compare output true.
// - Output advances index, masks entry, writes.
// - Index past count wraps to one.
// - Output completion flag after full table.
// - Fault on bad count or index.
// - Active flag follows rung enable.
// - Prescan sets active, output false.
// - Rung false clears active, output false.
// - Narrow mask and source sign-extended.
// - Program-to-run initialises output index.
// - Load advances index, writes source.
// - Load sets index one on wrap.
// - Load completion flag after full table.
// - Oversized load count raises major fault.
// - Load writes contiguous storage unchecked.
// - Compare raises no major fault, index unchanged.
`timescale 1ns/1ps
`default_nettype none
`include "mss_regs.vh"
module mss_top #(
  parameter TAW = 4
) (
  // Clock and reset
  input  wire        CLK,
  input  wire        RST_N,
  // AHB-Lite slave
  input  wire        HSEL,
  input  wire [11:0] HADDR,
  input  wire [1:0]  HTRANS,
  input  wire        HWRITE,
  input  wire [2:0]  HSIZE,
  input  wire [31:0] HWDATA,
  input  wire        HREADY,
  output wire [31:0] HRDATA,
  output wire        HREADYOUT,
  output wire        HRESP,
  // Rung outputs
  output wire        CMP_OUT,
  output wire        OUT_OUT,
  output wire        LOAD_OUT,
  output wire        FAULT
);
  localparam TSIZE = 1 << TAW;
  localparam [31:0] TSIZE_W = TSIZE;
  localparam [1:0] S_IDLE = 2'h0;
  localparam [1:0] S_READ = 2'h1;
  localparam [1:0] S_DONE = 2'h2;

  // Bus data phase capture
  reg        dp_wr_reg;
  reg        dp_rd_reg;
  reg [11:0] dp_addr_reg;
  reg [1:0]  bus_state_reg;
  reg [1:0]  bus_state_next;

  // Control record and operands
  reg        [31:0] ctrl_reg;
  reg signed [31:0] count_reg;
  reg signed [31:0] index_reg;
  reg        [31:0] mask_reg;
  reg        [31:0] source_reg;
  reg        [31:0] dest_reg;
  reg               cmp_out_reg;
  reg               out_act_reg;
  reg               out_cmp_reg;
  reg               out_out_reg;
  reg               ld_act_reg;
  reg               ld_cmp_reg;
  reg               ld_out_reg;
  reg               major_reg;
  reg               run_prev_reg;
  reg        [31:0] rdata_reg;

  wire        addr_ok   = HSEL & HREADY & HTRANS[1];
  wire        is_table  = dp_addr_reg[11:8] == 4'h1;
  wire [TAW-1:0] dp_tidx = dp_addr_reg[TAW+1:2];

  function [31:0] mss_sext;
    input [31:0] v;
    input [1:0]  w;
    begin
      case (w)
        `MSS_W_8:  mss_sext = {{24{v[7]}}, v[7:0]};
        `MSS_W_16: mss_sext = {{16{v[15]}}, v[15:0]};
        default:   mss_sext = v;
      endcase
    end
  endfunction

  wire [31:0] mask_x = mss_sext(mask_reg, ctrl_reg[`MSS_CTRL_MSK_W]);
  wire [31:0] src_x  = mss_sext(source_reg, ctrl_reg[`MSS_CTRL_SRC_W]);

  wire cmp_en  = ctrl_reg[`MSS_CTRL_CMP_EN];
  wire out_en  = ctrl_reg[`MSS_CTRL_OUT_EN];
  wire ld_en   = ctrl_reg[`MSS_CTRL_LOAD_EN];
  wire run     = ctrl_reg[`MSS_CTRL_RUN];
  wire prescan = ctrl_reg[`MSS_CTRL_PRESCAN];

  wire fault_w = (count_reg <= 0) | (index_reg < 0) | (index_reg > count_reg);

  wire signed [31:0] inc_idx = index_reg + 32'sh1;
  wire signed [31:0] out_idx = (inc_idx > count_reg) ? 32'sh1 : inc_idx;
  wire signed [31:0] ld_idx  = (ld_cmp_reg | (index_reg >= count_reg)) ? 32'sh1 : inc_idx;

  // Rising rung edges only; levels hold active and stop repeat steps
  wire out_step = out_en & ~out_act_reg & ~prescan & run;
  wire ld_step  = ld_en & ~ld_act_reg & ~prescan & run;

  // Output step outranks load when both rungs rise together
  wire out_go   = out_step & ~fault_w;
  wire ld_go    = ld_step & ~out_step & ~fault_w;

  wire run_rise = run & ~run_prev_reg;

  // Table memory: port a is current entry, port b is next output entry
  wire [31:0]    cur_entry;
  wire [31:0]    nxt_entry;
  wire [TAW-1:0] ld_addr = ld_idx[TAW-1:0];
  // load writes wherever the index lands, no bound check
  // A bus table write in the same cycle as a load step is lost
  wire           tbl_we  = ld_go | (dp_wr_reg & is_table);
  wire [TAW-1:0] tbl_wa  = ld_go ? ld_addr : dp_tidx;
  wire [31:0]    tbl_wd  = ld_go ? src_x : HWDATA;
  // Table read address goes in during the address phase, so the
  // entry is out of the memory after exactly one wait cycle
  wire           tab_rd  = addr_ok & ~HWRITE & (HADDR[11:8] == 4'h1);
  wire [TAW-1:0] a_tidx  = HADDR[TAW+1:2];
  wire [TAW-1:0] ra      = tab_rd ? a_tidx : index_reg[TAW-1:0];
  // Port a shows a bus word while the read waits; compare holds then
  wire           cmp_hold = (bus_state_reg == S_READ);

  mss_table_mem #(
    .AW (TAW),
    .DW (32)
  ) u_mem (
    .clk     (CLK),
    .we      (tbl_we),
    .waddr   (tbl_wa),
    .wdata   (tbl_wd),
    .raddr_a (ra),
    .rdata_a (cur_entry),
    .raddr_b (out_idx[TAW-1:0]),
    .rdata_b (nxt_entry)
  );

  // per-bit compare, a zero mask bit always matches
  wire [31:0] bit_hit;
  genvar gb;
  generate
    for (gb = 0; gb < 32; gb = gb + 1) begin : g_bit
      assign bit_hit[gb] = ~mask_x[gb] | (src_x[gb] == cur_entry[gb]);
    end
  endgenerate
  wire cmp_hit = &bit_hit;

  // Status word, one flag per bit
  wire [31:0] status_w;
  assign status_w[`MSS_ST_FAULT]   = fault_w;
  assign status_w[`MSS_ST_CMP_OUT] = cmp_out_reg;
  assign status_w[`MSS_ST_OUT_ACT] = out_act_reg;
  assign status_w[`MSS_ST_OUT_CMP] = out_cmp_reg;
  assign status_w[`MSS_ST_OUT_OUT] = out_out_reg;
  assign status_w[`MSS_ST_LD_ACT]  = ld_act_reg;
  assign status_w[`MSS_ST_LD_CMP]  = ld_cmp_reg;
  assign status_w[`MSS_ST_LD_OUT]  = ld_out_reg;
  assign status_w[`MSS_ST_MAJOR]   = major_reg;
  assign status_w[31:9]            = 23'h000000;

  // Fault record only while the major fault stands
  wire [31:0] fault_word = major_reg ? {16'h0000, `MSS_FAULT_TYPE, `MSS_FAULT_CODE} : 32'h00000000;

  // Bus state: table reads take one extra wait cycle
  always @* begin
    bus_state_next = S_IDLE;
    case (bus_state_reg)
      S_IDLE:  bus_state_next = (addr_ok & ~HWRITE & HADDR[11:8] == 4'h1) ? S_READ : S_IDLE;
      S_READ:  bus_state_next = S_DONE;
      S_DONE:  bus_state_next = S_IDLE;
      default: bus_state_next = S_IDLE;
    endcase
  end

  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      bus_state_reg <= S_IDLE;
      dp_wr_reg     <= 1'b0;
      dp_rd_reg     <= 1'b0;
      dp_addr_reg   <= 12'h000;
    end else begin
      bus_state_reg <= bus_state_next;
      if (HREADYOUT) begin
        dp_wr_reg   <= addr_ok & HWRITE;
        dp_rd_reg   <= addr_ok & ~HWRITE;
        dp_addr_reg <= HADDR;
      end
    end
  end

  assign HREADYOUT = ~(dp_rd_reg & is_table) | (bus_state_reg == S_DONE);
  assign HRESP     = 1'b0;

  // Register read mux; unmapped reads as zero
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rdata_reg <= `MSS_RST_WORD;
    end else if (bus_state_reg == S_READ) begin
      rdata_reg <= cur_entry;
    end else if (addr_ok & ~HWRITE) begin
      case (HADDR)
        `MSS_OFF_CTRL:   rdata_reg <= ctrl_reg;
        `MSS_OFF_STATUS: rdata_reg <= status_w;
        `MSS_OFF_COUNT:  rdata_reg <= count_reg;
        `MSS_OFF_INDEX:  rdata_reg <= index_reg;
        `MSS_OFF_MASK:   rdata_reg <= mask_reg;
        `MSS_OFF_SOURCE: rdata_reg <= source_reg;
        `MSS_OFF_DEST:   rdata_reg <= dest_reg;
        `MSS_OFF_FAULT:  rdata_reg <= fault_word;
        default:         rdata_reg <= `MSS_RST_WORD;
      endcase
    end
  end
  assign HRDATA = rdata_reg;

  wire wr_ctrl = dp_wr_reg & (dp_addr_reg == `MSS_OFF_CTRL);

  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ctrl_reg     <= `MSS_RST_WORD;
      count_reg    <= `MSS_RST_WORD;
      index_reg    <= `MSS_RST_WORD;
      mask_reg     <= `MSS_RST_WORD;
      source_reg   <= `MSS_RST_WORD;
      dest_reg     <= `MSS_RST_WORD;
      cmp_out_reg  <= 1'b0;
      out_cmp_reg  <= 1'b0;
      ld_cmp_reg   <= 1'b0;
      run_prev_reg <= 1'b0;
    end else begin
      run_prev_reg <= run;
      if (wr_ctrl) begin
        // Clear is a self-clearing strobe
        ctrl_reg <= HWDATA & 32'hFFFFFFDF;
      end
      if (dp_wr_reg & (dp_addr_reg == `MSS_OFF_COUNT)) begin
        count_reg <= HWDATA;
      end
      if (dp_wr_reg & (dp_addr_reg == `MSS_OFF_MASK)) begin
        mask_reg <= HWDATA;
      end
      if (dp_wr_reg & (dp_addr_reg == `MSS_OFF_SOURCE)) begin
        source_reg <= HWDATA;
      end
      if (!cmp_hold) begin
        cmp_out_reg <= cmp_en & ~prescan & cmp_hit;
      end
      if (run_rise) begin
        index_reg <= 32'sh0;
      end else if (dp_wr_reg & (dp_addr_reg == `MSS_OFF_INDEX)) begin
        index_reg <= HWDATA;
      end else if (out_go) begin
        // advance then mask entry to destination
        index_reg <= out_idx;
        dest_reg  <= nxt_entry & mask_x;
        out_cmp_reg <= (out_idx == count_reg);
      end else if (ld_go) begin
        index_reg <= ld_idx;
        ld_cmp_reg <= (ld_idx == count_reg);
      end
    end
  end

  // load count beyond table is a major fault; set wins over clear
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      major_reg <= 1'b0;
    end else if (ld_en & run & (count_reg > $signed(TSIZE_W))) begin
      major_reg <= 1'b1;
    end else if (wr_ctrl & HWDATA[`MSS_CTRL_CLEAR]) begin
      major_reg <= 1'b0;
    end
  end

  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      out_act_reg <= 1'b0;
      out_out_reg <= 1'b0;
      ld_act_reg  <= 1'b0;
      ld_out_reg  <= 1'b0;
    end else if (prescan) begin
      out_act_reg <= 1'b1;
      out_out_reg <= 1'b0;
      ld_act_reg  <= 1'b1;
      ld_out_reg  <= 1'b0;
    end else begin
      out_act_reg <= out_en;
      out_out_reg <= out_en & run;
      ld_act_reg  <= ld_en;
      ld_out_reg  <= ld_en & run;
    end
  end

  assign CMP_OUT  = cmp_out_reg;
  assign OUT_OUT  = out_out_reg;
  assign LOAD_OUT = ld_out_reg;
  assign FAULT    = fault_w;
endmodule // mss_top
`default_nettype wire

// ==== test/mss_chk_assertions.sv ====
// Checker of bus timing and rung outputs of the sequencer
`timescale 1ns/1ps
`default_nettype none
`include "mss_regs.vh"
module mss_chk #(
  parameter TAW = 4
) (
  // Clock and reset
  input wire logic        CLK,
  input wire logic        RST_N,
  // Bus
  input wire logic        HSEL,
  input wire logic [11:0] HADDR,
  input wire logic [1:0]  HTRANS,
  input wire logic        HWRITE,
  input wire logic [31:0] HWDATA,
  input wire logic        HREADY,
  input wire logic [31:0] HRDATA,
  input wire logic        HREADYOUT,
  input wire logic        HRESP,
  // Rungs
  input wire logic        CMP_OUT,
  input wire logic        OUT_OUT,
  input wire logic        LOAD_OUT,
  input wire logic        FAULT
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  wire         tk = HSEL & HREADY & HTRANS[1];
  wire         rt = tk & !HWRITE;
  wire         tr = rt & (HADDR >= 12'h100) & (HADDR < 12'h100 + (12'h4 << TAW));
  logic        wq_reg;
  logic        rq_reg;
  logic        rq2_reg;
  logic [11:0] aq_reg;
  logic [31:0] cnt_reg;
  logic [31:0] ctl_reg;
  // Shadow of count and control, written as the slave writes them
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      wq_reg  <= 1'b0;
      rq_reg  <= 1'b0;
      rq2_reg <= 1'b0;
      aq_reg  <= 12'h000;
      cnt_reg <= 32'h0;
      ctl_reg <= 32'h0;
    end else begin
      rq_reg  <= rt;
      rq2_reg <= rq_reg;
      if (HREADY) begin
        wq_reg <= tk & HWRITE;
        aq_reg <= HADDR;
        if (wq_reg && aq_reg == `MSS_OFF_COUNT) cnt_reg <= HWDATA;
        if (wq_reg && aq_reg == `MSS_OFF_CTRL) ctl_reg <= HWDATA;
      end
    end
  end
  bus_okay_a: assert property (HRESP == 1'b0)
    else $error("error response seen");
  reg_nowait_a: assert property (tk && HADDR < 12'h100 |=> HREADYOUT)
    else $error("register access stalled");
  tab_wait_a: assert property (tr |=> !HREADYOUT ##1 HREADYOUT)
    else $error("table read wait not one cycle");
  unmap_zero_a: assert property (rt && HADDR == 12'h020 |=> HRDATA == 32'h0)
    else $error("unmapped read not zero");
  rdata_hold_a: assert property (!rt && !rq_reg && !rq2_reg |=> $stable(HRDATA))
    else $error("read data moved without a read");
  fault_count_a: assert property ($signed(cnt_reg) < 1 |-> FAULT)
    else $error("fault flag low with bad count");
  out_idle_a: assert property (!ctl_reg[`MSS_CTRL_OUT_EN] [*3] |-> !OUT_OUT)
    else $error("output rung true while disabled");
  load_idle_a: assert property (!ctl_reg[`MSS_CTRL_LOAD_EN] [*3] |-> !LOAD_OUT)
    else $error("load rung true while disabled");
  prescan_quiet_a: assert property (ctl_reg[`MSS_CTRL_PRESCAN] [*3] |-> !OUT_OUT && !LOAD_OUT)
    else $error("rung true during prescan");
  cmp_hit_c: cover property ($rose(CMP_OUT));
  tab_rd_c: cover property (tr);
  out_act_c: cover property (ctl_reg[`MSS_CTRL_OUT_EN]);
endmodule // mss_chk
bind mss_top mss_chk #(.TAW(TAW)) mss_chk_i (.CLK(CLK), .RST_N(RST_N), .HSEL(HSEL), .HADDR(HADDR),
  .HTRANS(HTRANS), .HWRITE(HWRITE), .HWDATA(HWDATA), .HREADY(HREADY), .HRDATA(HRDATA),
  .HREADYOUT(HREADYOUT), .HRESP(HRESP), .CMP_OUT(CMP_OUT), .OUT_OUT(OUT_OUT), .LOAD_OUT(LOAD_OUT),
  .FAULT(FAULT));
`default_nettype wire

// ==== test/mss_prog_model.sv ====
// Program-side bus master reaching the sequencer registers
`timescale 1ns/1ps
`default_nettype none
module mss_prog_model (
  // Clock
  input  wire logic        CLK,
  // Bus
  input  wire logic        HREADY,
  input  wire logic [31:0] HRDATA,
  output var  logic        HSEL,
  output var  logic [11:0] HADDR,
  output var  logic [1:0]  HTRANS,
  output var  logic        HWRITE,
  output var  logic [2:0]  HSIZE,
  output var  logic [31:0] HWDATA
);
  initial begin
    HSEL   = 1'b0;
    HADDR  = 12'h000;
    HTRANS = 2'h0;
    HWRITE = 1'b0;
    HSIZE  = 3'h2;
    HWDATA = 32'h0;
  end
  // Ready and read data are taken at the rising edge itself
  task automatic hwait(output logic ok, output logic [31:0] q);
    ok = 1'b0;
    for (int n = 0; n < 32 && !ok; n++) begin
      @(posedge CLK);
      ok = (HREADY === 1'b1);
      q  = HRDATA;
    end
  endtask
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic ok);
    logic o1;
    @(posedge CLK);
    HSEL   <= 1'b1;
    HTRANS <= 2'h2;
    HADDR  <= a;
    HWRITE <= w;
    hwait(o1, q);
    HSEL   <= 1'b0;
    HTRANS <= 2'h0;
    HADDR  <= ~a;
    HWDATA <= d;
    hwait(ok, q);
    // Released data lines do not keep the last value
    HWDATA <= ~d;
    ok = ok & o1;
  endtask
endmodule // mss_prog_model
`default_nettype wire

// ==== test/tb_top.sv ====
// Self-checking bench of the masked step sequencer
`timescale 1ns/1ps
`default_nettype none
`include "mss_regs.vh"
module tb_top;
  logic        CLK;
  logic        RST_N;
  wire         HSEL, HWRITE, HREADYOUT, HRESP, CMP_OUT, OUT_OUT, LOAD_OUT, FAULT;
  wire  [1:0]  HTRANS;
  wire  [2:0]  HSIZE;
  wire  [11:0] HADDR;
  wire  [31:0] HWDATA, HRDATA;
  int          bad_count = 0;
  int          n_tests = 0;
  logic [31:0] t [1:3];
  // Run bit with 32-bit mask and source
  localparam logic [31:0] B = 32'h0000_0A08;
  mss_top mss_top_i (.CLK(CLK), .RST_N(RST_N), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
    .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA),
    .HREADYOUT(HREADYOUT), .HRESP(HRESP), .CMP_OUT(CMP_OUT), .OUT_OUT(OUT_OUT),
    .LOAD_OUT(LOAD_OUT), .FAULT(FAULT));
  mss_prog_model mss_prog_model_i (.CLK(CLK), .HREADY(HREADYOUT), .HRDATA(HRDATA), .HSEL(HSEL),
    .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA));
  initial begin
    CLK = 1'b0;
    forever #12.5 CLK = ~CLK;
  end
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic chkb(input logic g, input logic e);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
    logic ok;
    mss_prog_model_i.xfer(w, a, d, r, ok);
    if (!ok) begin
      bad_count++;
      report_and_stop();
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    acc(1'b1, a, d, r);
  endtask
  task automatic rc(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] r;
    acc(1'b0, a, 32'h0, r);
    chk(r, e);
  endtask
  task automatic rb(input int b, input logic e);
    logic [31:0] r;
    acc(1'b0, `MSS_OFF_STATUS, 32'h0, r);
    chkb(r[b], e);
  endtask
  task automatic step(input logic [31:0] base, input int b, input int s);
    wr(`MSS_OFF_CTRL, base | (32'h1 << b));
    rb(s, 1'b1);
    wr(`MSS_OFF_CTRL, base);
  endtask
  function automatic logic [11:0] ta(input int i);
    return `MSS_OFF_TABLE + 12'(4 * i);
  endfunction
  initial begin
    RST_N = 1'b0;
    t[1]  = 32'h1234_5A5A;
    t[2]  = 32'h0F0F_0F0F;
    t[3]  = 32'h8000_00A5;
    repeat (20) @(posedge CLK);
    RST_N <= 1'b1;
    rb(`MSS_ST_FAULT, 1'b1);
    rc(12'h020, 32'h0);
    wr(`MSS_OFF_COUNT, 32'h3);
    wr(`MSS_OFF_INDEX, 32'h2);
    wr(`MSS_OFF_CTRL, B);
    rc(`MSS_OFF_INDEX, 32'h0);
    rb(`MSS_ST_FAULT, 1'b0);
    for (int i = 1; i <= 3; i++) begin
      wr(`MSS_OFF_SOURCE, t[i]);
      step(B, `MSS_CTRL_LOAD_EN, `MSS_ST_LD_ACT);
      rc(`MSS_OFF_INDEX, i);
      rc(ta(i), t[i]);
    end
    rb(`MSS_ST_LD_CMP, 1'b1);
    t[1] = 32'h0000_0077;
    wr(`MSS_OFF_SOURCE, t[1]);
    step(B, `MSS_CTRL_LOAD_EN, `MSS_ST_LD_ACT);
    rc(`MSS_OFF_INDEX, 32'h1);
    rc(ta(1), t[1]);
    wr(`MSS_OFF_MASK, 32'h0F0F_0F0F);
    wr(`MSS_OFF_INDEX, 32'h0);
    for (int k = 0; k < 4; k++) begin
      step(B, `MSS_CTRL_OUT_EN, `MSS_ST_OUT_ACT);
      rc(`MSS_OFF_INDEX, k % 3 + 1);
      rc(`MSS_OFF_DEST, t[k % 3 + 1] & 32'h0F0F_0F0F);
      if (k == 2) rb(`MSS_ST_OUT_CMP, 1'b1);
    end
    wr(`MSS_OFF_CTRL, B | 32'h12);
    rb(`MSS_ST_OUT_ACT, 1'b1);
    rb(`MSS_ST_OUT_OUT, 1'b0);
    wr(`MSS_OFF_CTRL, B | 32'h2);
    rc(`MSS_OFF_INDEX, 32'h1);
    wr(`MSS_OFF_CTRL, B);
    rb(`MSS_ST_OUT_ACT, 1'b0);
    rb(`MSS_ST_OUT_OUT, 1'b0);
    wr(`MSS_OFF_CTRL, B | 32'h1);
    for (int i = 1; i <= 3; i++) begin
      wr(`MSS_OFF_INDEX, i);
      wr(`MSS_OFF_SOURCE, t[i] ^ 32'hF0F0_F0F0);
      rc(`MSS_OFF_INDEX, i);
      rb(`MSS_ST_CMP_OUT, 1'b1);
      wr(`MSS_OFF_SOURCE, t[i] ^ 32'h0000_0100);
      rb(`MSS_ST_CMP_OUT, 1'b0);
      chkb(CMP_OUT, 1'b0);
    end
    wr(`MSS_OFF_INDEX, 32'h1);
    wr(`MSS_OFF_MASK, 32'h0000_8000);
    step(32'h0000_0908, `MSS_CTRL_OUT_EN, `MSS_ST_OUT_ACT);
    rc(`MSS_OFF_DEST, t[2] & 32'hFFFF_8000);
    wr(`MSS_OFF_SOURCE, 32'h0000_0085);
    step(32'h0000_0208, `MSS_CTRL_LOAD_EN, `MSS_ST_LD_ACT);
    rc(ta(3), 32'hFFFF_FF85);
    wr(`MSS_OFF_INDEX, 32'hFFFF_FFFF);
    rb(`MSS_ST_FAULT, 1'b1);
    wr(`MSS_OFF_INDEX, 32'h4);
    rb(`MSS_ST_FAULT, 1'b1);
    wr(`MSS_OFF_INDEX, 32'h3);
    rb(`MSS_ST_FAULT, 1'b0);
    wr(`MSS_OFF_COUNT, 32'h10);
    step(B, `MSS_CTRL_LOAD_EN, `MSS_ST_LD_ACT);
    rb(`MSS_ST_MAJOR, 1'b0);
    wr(`MSS_OFF_COUNT, 32'h11);
    step(B, `MSS_CTRL_LOAD_EN, `MSS_ST_LD_ACT);
    rb(`MSS_ST_MAJOR, 1'b1);
    rc(`MSS_OFF_FAULT, {16'h0000, `MSS_FAULT_TYPE, `MSS_FAULT_CODE});
    wr(`MSS_OFF_CTRL, B | 32'h20);
    rb(`MSS_ST_MAJOR, 1'b0);
    report_and_stop();
  end
endmodule // tb_top
`default_nettype wire
